/* src/ehc_pkg.sv */
package ehc_pkg;

   localparam int unsigned CLK_PERIOD_PS = 25000;
   localparam int unsigned SAMP_MIN_NS   = 400;
   localparam int unsigned SAMP_CYC      =
      (SAMP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [4:0]  SAMP_LAST     = 5'(SAMP_CYC - 1);

   localparam int unsigned CNT_W     = 11;
   localparam logic [10:0] FLUSH_LAST = 11'h3FF;
   localparam logic [9:0]  WIN_S_LAST = 10'h1FF;
   localparam logic [9:0]  WIN_L_LAST = 10'h3FF;
   localparam logic [10:0] CNT_MAX    = 11'h7FF;

   localparam int unsigned WORD_W    = 16;
   localparam logic [4:0]  WORD_FULL = 5'h10;
   localparam int unsigned FIFO_D    = 16;
   localparam logic [1:0]  XOR_LAST  = 2'h3;

   typedef enum logic [3:0] {
      S_SELF  = 4'h1,
      S_WAIT  = 4'h2,
      S_VALID = 4'h4,
      S_DEAD  = 4'h8
   } ehc_stat_e;

   typedef enum logic [2:0] {
      F_SELF = 3'h1,
      F_LIVE = 3'h2,
      F_DEAD = 3'h4
   } ehc_fsm_e;

   typedef enum logic [1:0] {
      C_RAW = 2'h0,
      C_XOR = 2'h1,
      C_VN  = 2'h2
   } ehc_cond_e;

   typedef struct packed {
      logic [CNT_W-1:0] rep_cutoff;
      logic [CNT_W-1:0] win_cutoff;
      logic             win_large;
      logic             rep_fatal;
      ehc_cond_e        cond;
   } ehc_cfg_s;

   typedef struct packed {
      ehc_stat_e         status;
      logic [WORD_W-1:0] data;
   } ehc_seed_s;

endpackage

/* src/ehc_top.sv */
`timescale 1ns/1ps

module ehc_fifo #(
   parameter int unsigned W = 16,
   parameter int unsigned D = 16
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic         flush,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int unsigned AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0]         wp;
      logic [AW:0]         rp;
   } ehc_fifo_s;

   ehc_fifo_s s_r;
   ehc_fifo_s s_nxt;
   logic      full;

   assign full      = (s_r.wp[AW] != s_r.rp[AW]) && (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]);
   assign out_valid = s_r.wp != s_r.rp;
   assign in_ready  = !full;
   assign out_data  = s_r.mem[s_r.rp[AW-1:0]];

   always_comb begin
      s_nxt = s_r;
      if (flush) begin
         s_nxt.wp = '0;
         s_nxt.rp = '0;
      end else begin
         if (in_valid && !full) begin
            s_nxt.mem[s_r.wp[AW-1:0]] = in_data;
            s_nxt.wp = s_r.wp + 1'b1;
         end
         if (out_valid && out_ready) begin
            s_nxt.rp = s_r.rp + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end
endmodule

module ehc_top
   import ehc_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     resetn,
   input  wire logic     ce,
   input  wire logic     noise_in,
   input  wire ehc_cfg_s cfg,
   input  wire logic     rd_req,
   output ehc_seed_s     seed
);
   typedef struct packed {
      logic              sync1;
      logic              sync2;
      logic [4:0]        div;
      logic              have_prev;
      logic              prev;
      logic [CNT_W-1:0]  rep;
      logic [9:0]        win;
      logic              ref_bit;
      logic [CNT_W-1:0]  match;
      logic [CNT_W-1:0]  flush;
      ehc_fsm_e          fsm;
      logic              xacc;
      logic [1:0]        xcnt;
      logic              vfirst;
      logic              vhave;
      logic [WORD_W-1:0] asm_word;
      logic [4:0]        acnt;
      logic              out_valid;
      logic [WORD_W-1:0] out_word;
      ehc_seed_s         seed;
   } ehc_state_s;

   localparam ehc_state_s ST_RST = '{
      fsm:     F_SELF,
      seed:    '{status: S_SELF, data: '0},
      default: '0
   };

   ehc_state_s        s_r;
   ehc_state_s        s_nxt;
   logic              smp_en;
   logic              smp;
   logic              rep_hit;
   logic              win_hit;
   logic              clear;
   logic              bit_v;
   logic              bit_d;
   logic              push;
   logic              f_in_ready;
   logic              f_out_valid;
   logic              f_out_ready;
   logic [WORD_W-1:0] f_out_data;

   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      sat_inc = (v == CNT_MAX) ? v : v + 11'h001;
   endfunction

   assign seed = s_r.seed;

   always_comb begin
      s_nxt   = s_r;
      rep_hit = 1'b0;
      win_hit = 1'b0;
      clear   = 1'b0;
      bit_v   = 1'b0;
      bit_d   = 1'b0;
      // Only the second stage feeds any logic; the first may be metastable.
      s_nxt.sync1 = noise_in;
      s_nxt.sync2 = s_r.sync1;
      smp         = s_r.sync2;
      smp_en    = s_r.div == SAMP_LAST;
      s_nxt.div = smp_en ? 5'h00 : s_r.div + 5'h01;

      if (smp_en && s_r.fsm != F_DEAD) begin
         if (s_r.have_prev && smp == s_r.prev) begin
            s_nxt.rep = sat_inc(s_r.rep);
         end else begin
            s_nxt.rep = 11'h001;
         end
         s_nxt.prev      = smp;
         s_nxt.have_prev = 1'b1;
         rep_hit = (cfg.rep_cutoff != '0) && (s_nxt.rep >= cfg.rep_cutoff);
         if (s_r.win == 10'h000) begin
            s_nxt.ref_bit = smp;
            s_nxt.match   = 11'h001;
         end else if (smp == s_r.ref_bit) begin
            s_nxt.match = sat_inc(s_r.match);
         end
         win_hit = (cfg.win_cutoff != '0) && (s_nxt.match >= cfg.win_cutoff);
         if (s_r.win == (cfg.win_large ? WIN_L_LAST : WIN_S_LAST)) begin
            s_nxt.win = 10'h000;
         end else begin
            s_nxt.win = s_r.win + 10'h001;
         end
      end

      unique case (s_r.fsm)
         F_DEAD: begin
            clear = 1'b1;
         end
         F_SELF, F_LIVE: begin
            if (rep_hit && cfg.rep_fatal) begin
               s_nxt.fsm = F_DEAD;
               clear     = 1'b1;
            end else if (rep_hit || win_hit) begin
               s_nxt.fsm   = F_SELF;
               s_nxt.flush = '0;
               clear       = 1'b1;
            end else if (s_r.fsm == F_SELF && smp_en) begin
               // clean flush run before going live
               s_nxt.flush = s_r.flush + 11'h001;
               if (s_r.flush == FLUSH_LAST) begin
                  s_nxt.fsm   = F_LIVE;
                  s_nxt.flush = '0;
               end
            end
         end
      endcase

      // Samples arriving while a full word waits for FIFO room are not conditioned.
      push = s_r.fsm == F_LIVE && !clear && s_r.acnt == WORD_FULL;
      if (s_r.fsm == F_LIVE && !clear && smp_en && s_r.acnt != WORD_FULL) begin
         unique case (cfg.cond)
            C_XOR: begin
               s_nxt.xacc = s_r.xacc ^ smp;
               s_nxt.xcnt = s_r.xcnt + 2'h1;
               if (s_r.xcnt == XOR_LAST) begin
                  bit_v      = 1'b1;
                  bit_d      = s_r.xacc ^ smp;
                  s_nxt.xacc = 1'b0;
                  s_nxt.xcnt = 2'h0;
               end
            end
            C_VN: begin
               s_nxt.vhave  = !s_r.vhave;
               s_nxt.vfirst = smp;
               if (s_r.vhave && s_r.vfirst != smp) begin
                  // 01 gives 0, 10 gives 1
                  bit_v = 1'b1;
                  bit_d = s_r.vfirst;
               end
            end
            default: begin
               // raw bits pass when no folding is chosen
               bit_v = 1'b1;
               bit_d = smp;
            end
         endcase
      end
      if (bit_v) begin
         s_nxt.asm_word = {s_r.asm_word[WORD_W-2:0], bit_d};
         s_nxt.acnt     = s_r.acnt + 5'h01;
      end
      if (push && f_in_ready) begin
         s_nxt.acnt = 5'h00;
      end

      if (s_r.out_valid && rd_req) begin
         s_nxt.out_valid = 1'b0;
         s_nxt.out_word  = '0;
      end
      if (f_out_valid && f_out_ready) begin
         s_nxt.out_valid = 1'b1;
         s_nxt.out_word  = f_out_data;
      end

      if (clear) begin
         s_nxt.asm_word  = '0;
         s_nxt.acnt      = 5'h00;
         s_nxt.xacc      = 1'b0;
         s_nxt.xcnt      = 2'h0;
         s_nxt.vhave     = 1'b0;
         s_nxt.out_valid = 1'b0;
         s_nxt.out_word  = '0;
      end

      // words carry only the XOR, VN or raw conditioning set by cfg.cond; the consumer must hash them.
      unique case (s_nxt.fsm)
         F_DEAD:  s_nxt.seed.status = S_DEAD;
         F_SELF:  s_nxt.seed.status = S_SELF;
         default: s_nxt.seed.status = s_nxt.out_valid ? S_VALID : S_WAIT;
      endcase
      s_nxt.seed.data = (s_nxt.seed.status == S_VALID) ? s_nxt.out_word : '0;
   end

   assign f_out_ready = s_r.fsm == F_LIVE && !clear && !s_r.out_valid;

   ehc_fifo #(
      .W (WORD_W),
      .D (FIFO_D)
   ) u_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .ce        (ce),
      .flush     (clear),
      .in_valid  (push),
      .in_data   (s_r.asm_word),
      .in_ready  (f_in_ready),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   // rep, win and match are the only test counters
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= ST_RST;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence q_valid_read;
      ce && rd_req && seed.status == S_VALID;
   endsequence

   sequence q_changed_sample;
      ce && smp_en && s_r.fsm != F_DEAD && s_r.have_prev && smp != s_r.prev;
   endsequence

   // A fatal repetition hit outranks a window hit in the same sample, so it is excluded.
   sequence q_soft_alarm;
      ce && s_r.fsm == F_LIVE && !(rep_hit && cfg.rep_fatal) && (win_hit || rep_hit);
   endsequence

   a_dead_sticky: assert property (s_r.fsm == F_DEAD |=> s_r.fsm == F_DEAD)
      else $error("fatal halt was left");

   a_dead_no_data: assert property (seed.status == S_DEAD |-> seed.data == '0)
      else $error("halted source shows data");

   a_rep_restart: assert property (q_changed_sample |=> s_r.rep == 11'h001)
      else $error("repetition count did not restart");

   a_ref_capture: assert property (
      ce && smp_en && s_r.fsm != F_DEAD && s_r.win == 10'h000
      |=> s_r.ref_bit == $past(smp) && s_r.match == 11'h001)
      else $error("reference sample not captured");

   a_alarm_self: assert property (q_soft_alarm |=> seed.status == S_SELF)
      else $error("alarm did not return to self-test");

   a_rep_fatal: assert property (
      ce && s_r.fsm != F_DEAD && rep_hit && cfg.rep_fatal |=> seed.status == S_DEAD)
      else $error("repetition failure did not halt");

   a_read_wipe: assert property (q_valid_read |=> seed.status != S_VALID)
      else $error("word offered twice");

   a_whole_push: assert property (push |-> s_r.acnt == WORD_FULL)
      else $error("partial word pushed");

   a_vn_drop: assert property (
      ce && smp_en && cfg.cond == C_VN && s_r.vhave && s_r.vfirst == smp |-> !bit_v)
      else $error("equal pair produced a bit");

   a_vn_pairs: assert property (
      bit_v && cfg.cond == C_VN |-> s_r.vhave && bit_d == s_r.vfirst)
      else $error("extractor strobe outside a pair");
endmodule

/* verification/ehc_reader.sv */
`timescale 1ns/1ps

module ehc_reader
   import ehc_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      resetn,
   input  wire logic      en,
   input  wire ehc_seed_s seed,
   output logic           rd_req,
   output logic [15:0]    word,
   output int             n_taken,
   output logic [15:0]    cmp_word
);
   logic odd;

   // The request may stay up; only a valid status turns it into a read.
   assign rd_req = en;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         word     <= 16'h0000;
         n_taken  <= 0;
         cmp_word <= 16'h0000;
         odd      <= 1'b0;
      end else if (rd_req && seed.status == S_VALID) begin
         word    <= seed.data;
         n_taken <= n_taken + 1;
         odd     <= ~odd;
         if (odd) begin
            cmp_word <= word ^ seed.data;
         end
      end
   end
endmodule

/* verification/entropy_health_conditioner_tb.sv */
`timescale 1ns/1ps

module entropy_health_conditioner_tb
   import ehc_pkg::*;
;
   logic        clk        = 1'b0;
   logic        resetn     = 1'b0;
   logic        noise_in   = 1'b0;
   logic        en         = 1'b0;
   logic        stuck      = 1'b0;
   ehc_cfg_s    cfg        = '{11'h008, 11'h000, 1'b0, 1'b0, C_XOR};
   logic        rd_req;
   ehc_seed_s   seed;
   logic [15:0] word;
   int          n_taken;
   int          error_cnt  = 0;
   int          n_compared = 0;
   int          ph         = 0;
   int          n0;
   int          bad;

   always #12.5 clk = ~clk;

   // One level per sample interval, so raw samples alternate whatever the phase.
   always @(negedge clk) begin
      ph = ph + 1;
      if (!stuck) begin
         noise_in <= ph[4];
      end
   end

   ehc_top dut (
      .clk      (clk),
      .resetn   (resetn),
      .ce       (1'b1),
      .noise_in (noise_in),
      .cfg      (cfg),
      .rd_req   (rd_req),
      .seed     (seed)
   );

   ehc_reader rdr (
      .clk      (clk),
      .resetn   (resetn),
      .en       (en),
      .seed     (seed),
      .rd_req   (rd_req),
      .word     (word),
      .n_taken  (n_taken),
      .cmp_word ()
   );

   task automatic end_of_test();
      $display("Compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_st(input ehc_stat_e s, input int lim);
      int i;
      i = 0;
      while (seed.status !== s && i < lim) begin
         @(negedge clk);
         i++;
      end
   endtask

   task automatic rd_one();
      wait_st(S_VALID, 3000);
      chk(20'(seed.status), 20'(S_VALID));
      en = 1'b1;
      @(negedge clk);
      en = 1'b0;
      chk(20'(seed), {S_WAIT, 16'h0000});
   endtask

   task automatic do_reset();
      resetn = 1'b0;
      repeat (16) @(negedge clk);
      chk(20'(seed), {S_SELF, 16'h0000});
      resetn = 1'b1;
   endtask

   task automatic t_start();
      do_reset();
      repeat (16000) @(negedge clk);
      chk(20'(seed), {S_SELF, 16'h0000});
      rd_one();
      chk(20'(word), 20'h00000);
   endtask

   task automatic t_alarm();
      cfg.cond = C_VN;
      stuck    = 1'b1;
      wait_st(S_SELF, 300);
      chk(20'(seed), {S_SELF, 16'h0000});
      stuck = 1'b0;
      repeat (16000) @(negedge clk);
      chk(20'(seed.status), 20'(S_SELF));
      rd_one();
      chk(20'(word === 16'h0000 || word === 16'hFFFF), 20'h00001);
   endtask

   // The reader stalls until the buffer refuses, then drains it, one word every second cycle.
   task automatic t_fill();
      repeat (10000) @(negedge clk);
      n0 = n_taken;
      en = 1'b1;
      repeat (48) @(negedge clk);
      chk(20'(seed.status), 20'(S_WAIT));
      en = 1'b0;
      chk(20'((n_taken - n0) inside {[17:18]}), 20'h00001);
   endtask

   // The first raw word may still hold extractor bits, so the second is judged.
   task automatic t_raw();
      cfg.cond = C_RAW;
      rd_one();
      rd_one();
      chk(20'(word === 16'h5555 || word === 16'hAAAA), 20'h00001);
   endtask

   task automatic t_window();
      cfg.win_cutoff = 11'h101;
      bad = 0;
      repeat (16400) begin
         @(negedge clk);
         if (seed.status === S_SELF) begin
            bad++;
         end
      end
      chk(20'(bad), 20'h00000);
      cfg.win_cutoff = 11'h100;
      wait_st(S_SELF, 16700);
      chk(20'(seed.status), 20'(S_SELF));
   endtask

   task automatic t_fatal();
      cfg.win_cutoff = 11'h000;
      cfg.rep_fatal  = 1'b1;
      stuck          = 1'b1;
      wait_st(S_DEAD, 300);
      chk(20'(seed), {S_DEAD, 16'h0000});
      stuck = 1'b0;
      en    = 1'b1;
      bad   = 0;
      repeat (3000) begin
         @(negedge clk);
         if (seed !== {S_DEAD, 16'h0000}) begin
            bad++;
         end
      end
      en = 1'b0;
      chk(20'(bad), 20'h00000);
      do_reset();
      @(negedge clk);
      chk(20'(seed.status), 20'(S_SELF));
   endtask

   initial begin
      t_start();
      t_alarm();
      t_fill();
      t_raw();
      t_window();
      t_fatal();
      end_of_test();
   end

   // The scenarios need about 69000 cycles; this leaves a margin below the run limit.
   initial begin
      repeat (98000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
endmodule
